// ==== pfs_pkg.sv ====
// package of constants and types for the program flow and stack unit
package pfs_pkg;

  // widths
  localparam int PC_W          = 12;
  localparam int SEG_W         = 3;
  localparam int DATA_W        = 8;
  localparam int JUMP_LOW_W    = 9;
  localparam int INVOKE_LOW_W  = 8;
  localparam int STACK_DEPTH   = 8;

  // file register addresses
  localparam logic [7:0] PCL_ADDR    = 8'h02;
  localparam logic [7:0] STATUS_ADDR = 8'h03;

  // segment field position in the status register
  localparam int SEG_LSB = 5;
  localparam int SEG_MSB = 7;

  // largest legal operand of the segment select instruction
  localparam logic [SEG_W-1:0] SEG_SEL_MAX = 3'h3;

  // reset values
  localparam logic [PC_W-1:0]   PC_RESET    = 12'h000;
  localparam logic [SEG_W-1:0]  SEG_RESET   = 3'h0;
  localparam logic [PC_W-1:0]   STACK_RESET = 12'h000;

  // operations handed over by the instruction decoder
  typedef enum logic [3:0] {
    OP_OTHER,
    OP_JUMP,
    OP_INVOKE,
    OP_SEG_SEL,
    OP_BANK_SEL,
    OP_EXIT,
    OP_EXIT_SEG,
    OP_INT_EXIT,
    OP_INT_EXIT_ADJ,
    OP_LIT_EXIT,
    OP_DEC_SKIP,
    OP_INC_SKIP,
    OP_BIT_SKIP
  } pfs_op_e;

endpackage

// ==== pfs_stack.sv ====
// eight level shifting return address stack
`timescale 1ns/1ps
module pfs_stack
  import pfs_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic clk_en,
  // stack port
  pfs_stack_if.stk  sif
);

  logic [PC_W-1:0] level_r [STACK_DEPTH];

  assign sif.top_addr = level_r[0];

  // one flop row per level
  genvar g;
  generate
    for (g = 0; g < STACK_DEPTH; g++) begin : g_lvl
      logic [PC_W-1:0] push_val;
      logic [PC_W-1:0] pop_val;

      if (g == 0) begin : g_top
        assign push_val = sif.push_addr;
      end else begin : g_deeper
        assign push_val = level_r[g-1];
      end

      if (g < STACK_DEPTH - 1) begin : g_up
        assign pop_val = level_r[g+1];
      end else begin : g_bottom
        assign pop_val = level_r[g];
      end

      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          level_r[g] <= STACK_RESET;
        end else if (clk_en) begin
          if (sif.push) begin
            level_r[g] <= push_val;
          end else if (sif.pop) begin
            level_r[g] <= pop_val;
          end
        end
      end
    end
  endgenerate

endmodule // pfs_stack

// ==== pfs_stack_if.sv ====
// interface between the flow controller and the return stack
`timescale 1ns/1ps
interface pfs_stack_if;
  import pfs_pkg::*;
  logic            push;
  logic            pop;
  logic [PC_W-1:0] push_addr;
  logic [PC_W-1:0] top_addr;

  modport ctl (output push, output pop, output push_addr, input top_addr);
  modport stk (input push, input pop, input push_addr, output top_addr);
endinterface

// ==== pfs_unit.sv ====
// program counter, segment bits, call and return control, skip handling
`timescale 1ns/1ps
module pfs_unit
  import pfs_pkg::*;
(
  // clock, reset, enable
  input  wire logic                core_clk,
  input  wire logic                reset,
  input  wire logic                clk_en,
  // decoded instruction
  input  wire logic                instr_valid,
  input  wire pfs_op_e             instr_op,
  input  wire logic [8:0]          instr_target,
  input  wire logic [DATA_W-1:0]   instr_literal,
  input  wire logic [SEG_W-1:0]    instr_segment,
  input  wire logic                bit_test_true,
  // accumulator and selected file register
  input  wire logic [DATA_W-1:0]   acc_in,
  input  wire logic [DATA_W-1:0]   fr_rdata,
  // file register writes from the rest of the core
  input  wire logic                fr_wr_en,
  input  wire logic [7:0]          fr_addr,
  input  wire logic [DATA_W-1:0]   fr_wdata,
  // flow state
  output logic                     instr_ready_r,
  output logic [PC_W-1:0]          pc_r,
  output logic [SEG_W-1:0]         program_segment_bits_r,
  output logic                     flush_r,
  output logic                     skip_active_r,
  output logic                     seg_sel_err_r,
  // results toward the core
  output logic                     fr_res_wr_r,
  output logic [DATA_W-1:0]        fr_res_data_r,
  output logic                     acc_wr_r,
  output logic [DATA_W-1:0]        acc_data_r,
  output logic                     rtc_add_r,
  output logic [DATA_W-1:0]        rtc_add_val_r,
  output logic                     int_exit_r
);

  ////////////////////////////////////////////////////////////////////////
  // decode helpers

  // select instructions that a taken skip passes over as well
  function automatic logic is_select(input pfs_op_e op);
    return (op == OP_SEG_SEL) || (op == OP_BANK_SEL);
  endfunction

  // instructions that pop the return stack
  function automatic logic is_exit(input pfs_op_e op);
    return (op == OP_EXIT) || (op == OP_EXIT_SEG) || (op == OP_INT_EXIT) ||
           (op == OP_INT_EXIT_ADJ) || (op == OP_LIT_EXIT);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state and internal signals

  typedef enum logic [0:0] {
    PFS_RUN,
    PFS_FLUSH
  } pfs_state_e;

  pfs_state_e            state_r;
  pfs_state_e            state_nxt;
  logic                  exec;
  logic                  annul;
  logic                  pc_load;
  logic [PC_W-1:0]       pc_nxt;
  logic [PC_W-1:0]       pc_inc;
  logic [DATA_W-1:0]     fr_dec;
  logic [DATA_W-1:0]     fr_inc;
  logic                  skip_take;
  logic                  pcl_write;
  logic                  status_write;

  pfs_stack_if sif ();

  // instruction accepted this cycle
  assign exec      = clk_en && instr_valid && instr_ready_r;
  // accepted while a skip is pending: dropped
  assign annul     = exec && skip_active_r;
  assign pc_inc    = pc_r + 12'h001;
  assign fr_dec    = fr_rdata - 8'h01;
  assign fr_inc    = fr_rdata + 8'h01;
  assign pcl_write = fr_wr_en && (fr_addr == PCL_ADDR);
  // status byte carries the segment field
  assign status_write = fr_wr_en && (fr_addr == STATUS_ADDR);

  ////////////////////////////////////////////////////////////////////////
  // return stack

  pfs_stack u_stack (
    .core_clk (core_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .sif      (sif.stk)
  );

  // push on invoke, pop on any exit
  always_comb begin
    sif.push      = 1'b0;
    sif.pop       = 1'b0;
    sif.push_addr = pc_inc;
    if (exec && !annul) begin
      // return address is counter plus one
      if (instr_op == OP_INVOKE) begin
        sif.push = 1'b1;
      end
      if (is_exit(instr_op)) begin
        sif.pop = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next program counter

  always_comb begin
    pc_load = 1'b0;
    pc_nxt  = pc_inc;
    if (exec && !annul) begin
      case (instr_op)
        OP_JUMP: begin
          pc_load = 1'b1;
          pc_nxt  = {program_segment_bits_r, instr_target[JUMP_LOW_W-1:0]};
        end
        OP_INVOKE: begin
          pc_load = 1'b1;
          pc_nxt  = {program_segment_bits_r, 1'b0, instr_target[INVOKE_LOW_W-1:0]};
        end
        OP_EXIT, OP_EXIT_SEG, OP_INT_EXIT, OP_INT_EXIT_ADJ, OP_LIT_EXIT: begin
          pc_load = 1'b1;
          pc_nxt  = sif.top_addr;
        end
        default: begin
          pc_load = 1'b0;
          pc_nxt  = pc_inc;
        end
      endcase
    end
    if (pcl_write) begin
      pc_load = 1'b1;
      pc_nxt  = {program_segment_bits_r, 1'b0, fr_wdata};
    end
  end

  // skip decision for the test instructions
  always_comb begin
    skip_take = 1'b0;
    if (exec && !annul) begin
      case (instr_op)
        OP_DEC_SKIP: skip_take = (fr_dec == 8'h00);
        OP_INC_SKIP: skip_take = (fr_inc == 8'h00);
        OP_BIT_SKIP: skip_take = bit_test_true;
        default:     skip_take = 1'b0;
      endcase
    end
  end

  // flush sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PFS_RUN: begin
        if (pc_load) begin
          state_nxt = PFS_FLUSH;
        end
      end
      PFS_FLUSH: begin
        state_nxt = PFS_RUN;
      end
      default: begin
        state_nxt = PFS_RUN;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  // flow state machine and ready
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_r       <= PFS_RUN;
      instr_ready_r <= 1'b1;
      flush_r       <= 1'b0;
    end else if (clk_en) begin
      state_r       <= state_nxt;
      instr_ready_r <= (state_nxt == PFS_RUN);
      flush_r       <= (state_nxt == PFS_FLUSH);
    end
  end

  // program counter
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pc_r <= PC_RESET;
    end else if (clk_en) begin
      if (pc_load || exec) begin
        pc_r <= pc_nxt;
      end
    end
  end

  // segment bits
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      program_segment_bits_r <= SEG_RESET;
      seg_sel_err_r          <= 1'b0;
    end else if (clk_en) begin
      seg_sel_err_r <= 1'b0;
      if (exec && !annul && instr_op == OP_SEG_SEL) begin
        if (instr_segment <= SEG_SEL_MAX) begin
          program_segment_bits_r <= instr_segment;
        end else begin
          seg_sel_err_r <= 1'b1;
        end
      end else if (exec && !annul && instr_op == OP_EXIT_SEG) begin
        program_segment_bits_r <= sif.top_addr[PC_W-1 -: SEG_W];
      end else if (status_write) begin
        program_segment_bits_r <= fr_wdata[SEG_MSB:SEG_LSB];
      end
    end
  end

  // skip pending flag
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      skip_active_r <= 1'b0;
    end else if (clk_en) begin
      if (skip_take) begin
        skip_active_r <= 1'b1;
      end else if (annul) begin
        skip_active_r <= is_select(instr_op);
      end
    end
  end

  // file register result for increment and decrement
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      fr_res_wr_r   <= 1'b0;
      fr_res_data_r <= 8'h00;
    end else if (clk_en) begin
      fr_res_wr_r <= 1'b0;
      if (exec && !annul) begin
        case (instr_op)
          OP_DEC_SKIP: begin
            fr_res_wr_r   <= 1'b1;
            fr_res_data_r <= fr_dec;
          end
          OP_INC_SKIP: begin
            fr_res_wr_r   <= 1'b1;
            fr_res_data_r <= fr_inc;
          end
          default: begin
            fr_res_wr_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // accumulator load and timer adjust
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      acc_wr_r      <= 1'b0;
      acc_data_r    <= 8'h00;
      rtc_add_r     <= 1'b0;
      rtc_add_val_r <= 8'h00;
      int_exit_r    <= 1'b0;
    end else if (clk_en) begin
      acc_wr_r   <= 1'b0;
      rtc_add_r  <= 1'b0;
      int_exit_r <= 1'b0;
      if (exec && !annul) begin
        if (instr_op == OP_LIT_EXIT) begin
          acc_wr_r   <= 1'b1;
          acc_data_r <= instr_literal;
        end
        if (instr_op == OP_INT_EXIT || instr_op == OP_INT_EXIT_ADJ) begin
          int_exit_r <= 1'b1;
        end
        if (instr_op == OP_INT_EXIT_ADJ) begin
          rtc_add_r     <= 1'b1;
          rtc_add_val_r <= acc_in;
        end
      end
    end
  end

endmodule // pfs_unit

// ==== pfs_unit_properties.sv ====
// assertion checker for the program flow and stack unit
`timescale 1ns/1ps
module pfs_unit_properties
  import pfs_pkg::*;
(
  // clock, reset, enable
  input wire logic              core_clk,
  input wire logic              reset,
  input wire logic              clk_en,
  // decoded instruction
  input wire logic              instr_valid,
  input wire pfs_op_e           instr_op,
  input wire logic [8:0]        instr_target,
  input wire logic [7:0]        instr_literal,
  input wire logic [2:0]        instr_segment,
  input wire logic [7:0]        acc_in,
  input wire logic [7:0]        fr_rdata,
  // file register writes
  input wire logic              fr_wr_en,
  input wire logic [7:0]        fr_addr,
  input wire logic [7:0]        fr_wdata,
  // flow state and results
  input wire logic              instr_ready_r,
  input wire logic [11:0]       pc_r,
  input wire logic [2:0]        program_segment_bits_r,
  input wire logic              flush_r,
  input wire logic              skip_active_r,
  input wire logic              seg_sel_err_r,
  input wire logic              fr_res_wr_r,
  input wire logic [7:0]        fr_res_data_r,
  input wire logic              acc_wr_r,
  input wire logic [7:0]        acc_data_r,
  input wire logic              rtc_add_r,
  input wire logic [7:0]        rtc_add_val_r,
  input wire logic              int_exit_r
);
  ////////////////////////////////////////////////////////////////////////////
  // instruction really executed this cycle
  logic tk;
  logic fw;
  assign tk = clk_en && instr_valid && instr_ready_r && !skip_active_r && !fr_wr_en;
  assign fw = clk_en && fr_wr_en && !instr_valid;

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////
  property p_jump;
    tk && instr_op == OP_JUMP |=> pc_r == {$past(program_segment_bits_r), $past(instr_target)};
  endproperty
  a_jump: assert property (p_jump) else $error("jump target wrong");
  property p_invoke;
    tk && instr_op == OP_INVOKE |=> pc_r == {$past(program_segment_bits_r), 1'b0, $past(instr_target[7:0])};
  endproperty
  a_invoke: assert property (p_invoke) else $error("invoke target wrong");
  property p_flush;
    tk && (instr_op == OP_JUMP || instr_op == OP_INVOKE || instr_op == OP_EXIT) |=> flush_r && !instr_ready_r && !acc_wr_r;
  endproperty
  a_flush: assert property (p_flush) else $error("no flush after branch");
  property p_seg_sel;
    tk && instr_op == OP_SEG_SEL && instr_segment <= SEG_SEL_MAX
      |=> program_segment_bits_r == $past(instr_segment) && !seg_sel_err_r;
  endproperty
  a_seg_sel: assert property (p_seg_sel) else $error("segment select wrong");
  property p_seg_err;
    tk && instr_op == OP_SEG_SEL && instr_segment > SEG_SEL_MAX |=> seg_sel_err_r && $stable(program_segment_bits_r);
  endproperty
  a_seg_err: assert property (p_seg_err) else $error("bad segment not refused");
  property p_dec;
    tk && instr_op == OP_DEC_SKIP
      |=> fr_res_wr_r && fr_res_data_r == $past(fr_rdata) - 8'h01 && skip_active_r == ($past(fr_rdata) == 8'h01);
  endproperty
  a_dec: assert property (p_dec) else $error("decrement skip wrong");
  property p_lit;
    tk && instr_op == OP_LIT_EXIT |=> acc_wr_r && acc_data_r == $past(instr_literal) && flush_r;
  endproperty
  a_lit: assert property (p_lit) else $error("literal exit wrong");
  property p_adj;
    tk && instr_op == OP_INT_EXIT_ADJ |=> rtc_add_r && int_exit_r && rtc_add_val_r == $past(acc_in);
  endproperty
  a_adj: assert property (p_adj) else $error("timer adjust exit wrong");
  property p_pc_wr;
    fw && fr_addr == PCL_ADDR |=> pc_r == {$past(program_segment_bits_r), 1'b0, $past(fr_wdata)} && flush_r;
  endproperty
  a_pc_wr: assert property (p_pc_wr) else $error("counter low write wrong");
  property p_st_wr;
    fw && fr_addr == STATUS_ADDR |=> program_segment_bits_r == $past(fr_wdata[7:5]);
  endproperty
  a_st_wr: assert property (p_st_wr) else $error("status segment write wrong");

  // main scenarios
  c_jump: cover property (tk && instr_op == OP_JUMP);
  c_skip: cover property (skip_active_r && instr_valid && instr_op == OP_SEG_SEL);
  c_err: cover property (seg_sel_err_r);
endmodule // pfs_unit_properties

bind pfs_unit pfs_unit_properties u_props (.core_clk, .reset, .clk_en, .instr_valid, .instr_op, .instr_target,
  .instr_literal, .instr_segment, .acc_in, .fr_rdata, .fr_wr_en, .fr_addr, .fr_wdata, .instr_ready_r, .pc_r,
  .program_segment_bits_r, .flush_r, .skip_active_r, .seg_sel_err_r, .fr_res_wr_r, .fr_res_data_r, .acc_wr_r,
  .acc_data_r, .rtc_add_r, .rtc_add_val_r, .int_exit_r);

// ==== tb.sv ====
// self-checking testbench for the program flow and stack unit
`timescale 1ns/1ps
module tb;
  import pfs_pkg::*;
  // stimulus
  logic core_clk, reset, clk_en, instr_valid, bit_test_true, fr_wr_en;
  pfs_op_e instr_op;
  logic [8:0] instr_target;
  logic [7:0] instr_literal, acc_in, fr_rdata, fr_addr, fr_wdata;
  logic [2:0] instr_segment;
  // observed
  logic instr_ready_r, flush_r, skip_active_r, seg_sel_err_r, fr_res_wr_r, acc_wr_r, rtc_add_r, int_exit_r;
  logic [11:0] pc_r;
  logic [2:0] program_segment_bits_r;
  logic [7:0] fr_res_data_r, acc_data_r, rtc_add_val_r;
  int num_errors, num_checks, cyc;

  pfs_unit uut (.core_clk, .reset, .clk_en, .instr_valid, .instr_op, .instr_target, .instr_literal,
    .instr_segment, .bit_test_true, .acc_in, .fr_rdata, .fr_wr_en, .fr_addr, .fr_wdata, .instr_ready_r, .pc_r,
    .program_segment_bits_r, .flush_r, .skip_active_r, .seg_sel_err_r, .fr_res_wr_r, .fr_res_data_r,
    .acc_wr_r, .acc_data_r, .rtc_add_r, .rtc_add_val_r, .int_exit_r);

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      summarize();
    end
  end

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // offer one instruction once ready, return when results settle
  task automatic issue(input pfs_op_e op, input logic [8:0] tgt, input logic [7:0] lit, input logic [2:0] sg,
                       input logic [7:0] frd);
    while (instr_ready_r !== 1'b1) begin
      @(posedge core_clk);
      #1;
    end
    @(posedge core_clk);
    instr_valid <= 1'b1;
    instr_op <= op;
    instr_target <= tgt;
    instr_literal <= lit;
    acc_in <= lit;
    instr_segment <= sg;
    fr_rdata <= frd;
    @(posedge core_clk);
    instr_valid <= 1'b0;
    #1;
  endtask

  task automatic fwr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    fr_wr_en <= 1'b1;
    fr_addr <= a;
    fr_wdata <= d;
    @(posedge core_clk);
    fr_wr_en <= 1'b0;
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_branch();
    issue(OP_SEG_SEL, 9'h000, 8'h00, 3'h3, 8'h00);
    chk(program_segment_bits_r, 12'h003);
    issue(OP_SEG_SEL, 9'h000, 8'h00, 3'h5, 8'h00);
    chk(seg_sel_err_r, 12'h001);
    chk(program_segment_bits_r, 12'h003);
    issue(OP_JUMP, 9'h1a5, 8'h00, 3'h0, 8'h00);
    chk(pc_r, 12'h7a5);
    chk(flush_r, 12'h001);
    issue(OP_INVOKE, 9'h1c3, 8'h00, 3'h0, 8'h00);
    chk(pc_r, 12'h6c3);
    issue(OP_SEG_SEL, 9'h000, 8'h00, 3'h1, 8'h00);
    issue(OP_EXIT_SEG, 9'h000, 8'h00, 3'h0, 8'h00);
    chk(pc_r, 12'h7a6);
    chk(program_segment_bits_r, 12'h003);
  endtask

  // nine nested invokes, nine returns of mixed kinds
  task automatic t_stack();
    logic [11:0] rets [9];
    logic [11:0] e;
    pfs_op_e ops [5];
    ops = '{OP_EXIT, OP_EXIT_SEG, OP_INT_EXIT, OP_INT_EXIT_ADJ, OP_LIT_EXIT};
    issue(OP_SEG_SEL, 9'h000, 8'h00, 3'h0, 8'h00);
    issue(OP_JUMP, 9'h005, 8'h00, 3'h0, 8'h00);
    for (int i = 0; i < 9; i++) begin
      rets[i] = (i == 0) ? 12'h006 : 12'(i * 16 + 1);
      issue(OP_INVOKE, 9'((i + 1) * 16), 8'h00, 3'h0, 8'h00);
      chk(pc_r, 12'((i + 1) * 16));
    end
    for (int j = 0; j < 9; j++) begin
      e = (j < 8) ? rets[8 - j] : rets[1];
      issue(ops[j % 5], 9'h000, 8'(8'h30 + j), 3'h0, 8'h00);
      chk(pc_r, e);
      if (ops[j % 5] == OP_LIT_EXIT) chk(acc_data_r, 12'(8'h30 + j));
      if (ops[j % 5] == OP_INT_EXIT_ADJ) chk(rtc_add_val_r, 12'(8'h30 + j));
      if (ops[j % 5] == OP_INT_EXIT) chk(int_exit_r, 12'h001);
    end
  endtask

  task automatic t_skip();
    issue(OP_DEC_SKIP, 9'h000, 8'h00, 3'h0, 8'h01);
    chk(fr_res_data_r, 12'h000);
    chk(skip_active_r, 12'h001);
    issue(OP_SEG_SEL, 9'h000, 8'h00, 3'h2, 8'h00);
    chk(skip_active_r, 12'h001);
    issue(OP_JUMP, 9'h0ff, 8'h00, 3'h0, 8'h00);
    chk(skip_active_r, 12'h000);
    chk(pc_r, 12'h014);
    chk(program_segment_bits_r, 12'h000);
    issue(OP_INC_SKIP, 9'h000, 8'h00, 3'h0, 8'hff);
    chk(skip_active_r, 12'h001);
    issue(OP_OTHER, 9'h000, 8'h00, 3'h0, 8'h00);
    issue(OP_INC_SKIP, 9'h000, 8'h00, 3'h0, 8'h10);
    chk(fr_res_data_r, 12'h011);
    chk(skip_active_r, 12'h000);
    bit_test_true <= 1'b1;
    issue(OP_BIT_SKIP, 9'h000, 8'h00, 3'h0, 8'h00);
    chk(skip_active_r, 12'h001);
    issue(OP_BANK_SEL, 9'h000, 8'h00, 3'h0, 8'h00);
    chk(skip_active_r, 12'h001);
    issue(OP_OTHER, 9'h000, 8'h00, 3'h0, 8'h00);
    chk(skip_active_r, 12'h000);
  endtask

  task automatic t_fwr();
    fwr(STATUS_ADDR, 8'h40);
    chk(program_segment_bits_r, 12'h002);
    fwr(PCL_ADDR, 8'h77);
    chk(pc_r, 12'h477);
    chk(flush_r, 12'h001);
    repeat (2) @(posedge core_clk);
    clk_en <= 1'b0;
    issue(OP_JUMP, 9'h000, 8'h00, 3'h0, 8'h00);
    chk(pc_r, 12'h477);
    clk_en <= 1'b1;
  endtask

  // mid-run reset clears segment, skip and stack
  task automatic t_reset();
    issue(OP_SEG_SEL, 9'h000, 8'h00, 3'h2, 8'h00);
    issue(OP_INVOKE, 9'h0a0, 8'h00, 3'h0, 8'h00);
    issue(OP_DEC_SKIP, 9'h000, 8'h00, 3'h0, 8'h01);
    @(posedge core_clk);
    reset <= 1'b1;
    @(posedge core_clk);
    reset <= 1'b0;
    #1;
    chk(program_segment_bits_r, {9'h000, SEG_RESET});
    chk(skip_active_r, 12'h000);
    issue(OP_EXIT, 9'h000, 8'h00, 3'h0, 8'h00);
    chk(pc_r, STACK_RESET);
  endtask

  task automatic summarize();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {num_errors, num_checks, cyc} = '0;
    {reset, clk_en} = 2'b11;
    {instr_valid, bit_test_true, fr_wr_en} = 3'b000;
    instr_op = OP_OTHER;
    {instr_target, instr_literal, acc_in, fr_rdata, fr_addr, fr_wdata, instr_segment} = '0;
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    t_branch();
    t_stack();
    t_skip();
    t_fwr();
    t_reset();
    summarize();
  end
endmodule // tb
